// File: core/mvo_pkg.sv
package mvo_pkg;

    localparam int          ADDR_W         = 12;
    // Register byte offsets
    localparam logic [11:0] ADDR_INSTR     = 12'h000;
    localparam logic [11:0] ADDR_WORK      = 12'h004;
    localparam logic [11:0] ADDR_STATUS    = 12'h008;
    localparam logic [11:0] ADDR_CONFIG    = 12'h00C;
    localparam logic [11:0] ADDR_LAST      = 12'h010;
    localparam logic [2:0]  FILE_PAGE      = 3'h1;
    // Reset values
    localparam logic [7:0]  RST_WORK       = 8'h00;
    localparam logic [7:0]  RST_STATUS     = 8'h00;
    localparam logic [7:0]  RST_CONFIG     = 8'hFF;
    localparam logic [13:0] RST_INSTR      = 14'h0000;
    // Status field
    localparam int          ST_ZERO        = 0;
    // Opcode fields
    localparam logic [5:0]  OP_OR_FILE     = 6'h04;
    localparam logic [5:0]  OP_COPY_FILE   = 6'h08;
    localparam logic [6:0]  OP_STORE_WORK  = 7'h01;
    localparam logic [13:0] OP_CONFIG_LOAD = 14'h0062;
    localparam int          DEST_BIT       = 7;
    // Responses
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [2:0] {
        KIND_NONE  = 3'h0,
        KIND_OR    = 3'h1,
        KIND_COPY  = 3'h3,
        KIND_STORE = 3'h2,
        KIND_CFG   = 3'h6
    } mvo_kind_t;

endpackage : mvo_pkg

// File: core/mvo_exec.sv
`timescale 1ns/10ps
module mvo_exec
    import mvo_pkg::*;
(
    // Instruction and operands
    input  wire logic [13:0] instr,
    input  wire logic [7:0]  work_val,
    input  wire logic [7:0]  file_val,
    // Effects
    output mvo_kind_t        kind,
    output logic [7:0]       result,
    output logic             work_we,
    output logic             file_we,
    output logic             zero_we,
    output logic             zero_val,
    output logic             cfg_we
);

    always_comb begin
        kind    = KIND_NONE;
        result  = work_val;
        work_we = 1'b0;
        file_we = 1'b0;
        zero_we = 1'b0;
        cfg_we  = 1'b0;
        if (instr[13:8] == OP_OR_FILE) begin
            kind    = KIND_OR;
            result  = work_val | file_val;
            zero_we = 1'b1;
            file_we = instr[DEST_BIT];
            work_we = !instr[DEST_BIT];
        end else if (instr[13:8] == OP_COPY_FILE) begin
            kind    = KIND_COPY;
            result  = file_val;
            zero_we = 1'b1;
            file_we = instr[DEST_BIT];
            work_we = !instr[DEST_BIT];
        end else if (instr[13:7] == OP_STORE_WORK) begin
            kind    = KIND_STORE;
            file_we = 1'b1;
        end else if (instr == OP_CONFIG_LOAD) begin
            kind    = KIND_CFG;
            cfg_we  = 1'b1;
        end
        zero_val = (result == 8'h00);
    end

endmodule : mvo_exec

// File: core/mvo_core.sv
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module mvo_core
    import mvo_pkg::*;
#(
    parameter int FILE_DEPTH = 128
)(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Write address
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    // Write data
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // Write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // Read address
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    // Read data
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready
);

    ////////////////////////////////////////////////////////////////////////////
    logic [ADDR_W-1:0] aw_addr_reg;
    logic              aw_held_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              w_held_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;
    logic [7:0]        work_reg;
    logic [7:0]        status_reg;
    logic [7:0]        config_reg;
    logic [13:0]       instr_reg;
    mvo_kind_t         last_kind_reg;
    logic [7:0]        file_mem [FILE_DEPTH];

    logic              wr_go;
    logic              exec_go;
    logic [6:0]        exec_f;
    mvo_kind_t         kind;
    logic [7:0]        result;
    logic              work_we;
    logic              file_we;
    logic              zero_we;
    logic              zero_val;
    logic              cfg_we;

    // Shared by the read and write decoders
    function automatic logic is_file(input logic [ADDR_W-1:0] a);
        return (a[11:9] == FILE_PAGE) && (a[1:0] == 2'h0);
    endfunction : is_file

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return is_file(a) || a == ADDR_INSTR || a == ADDR_WORK || a == ADDR_STATUS
            || a == ADDR_CONFIG || a == ADDR_LAST;
    endfunction : is_mapped

    ////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    assign awready = !aw_held_reg;
    assign wready  = !w_held_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign wr_go   = aw_held_reg && w_held_reg && !bvalid_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (awvalid && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= awaddr;
        end else if (wr_go) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (wvalid && !w_held_reg) begin
            w_held_reg <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
        end else if (wr_go) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= is_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Execution: a full 14-bit write to the instruction register runs it at once
    assign exec_go = wr_go && aw_addr_reg == ADDR_INSTR && w_strb_reg[1:0] == 2'h3;
    assign exec_f  = w_data_reg[6:0];

    mvo_exec u_exec (
        .instr    (w_data_reg[13:0]),
        .work_val (work_reg),
        .file_val (file_mem[exec_f]),
        .kind     (kind),
        .result   (result),
        .work_we  (work_we),
        .file_we  (file_we),
        .zero_we  (zero_we),
        .zero_val (zero_val),
        .cfg_we   (cfg_we)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_reg     <= RST_INSTR;
            last_kind_reg <= KIND_NONE;
        end else if (exec_go) begin
            instr_reg     <= w_data_reg[13:0];
            last_kind_reg <= kind;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            work_reg <= RST_WORK;
        end else if (exec_go && work_we) begin
            work_reg <= result;
        end else if (wr_go && aw_addr_reg == ADDR_WORK && w_strb_reg[0]) begin
            work_reg <= w_data_reg[7:0];
        end
    end

    // Only Z is touched by execution; the other flags keep their value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= RST_STATUS;
        end else if (exec_go && zero_we) begin
            status_reg[ST_ZERO] <= zero_val;
        end else if (wr_go && aw_addr_reg == ADDR_STATUS && w_strb_reg[0]) begin
            status_reg <= w_data_reg[7:0];
        end
    end

    // Bus path kept so software can avoid the legacy load
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_reg <= RST_CONFIG;
        end else if (exec_go && cfg_we) begin
            config_reg <= work_reg;
        end else if (wr_go && aw_addr_reg == ADDR_CONFIG && w_strb_reg[0]) begin
            config_reg <= w_data_reg[7:0];
        end
    end

    // Data memory has no reset; software initialises it
    always_ff @(posedge aclk) begin
        if (exec_go && file_we) begin
            file_mem[exec_f] <= (kind == KIND_STORE) ? work_reg : result;
        end else if (wr_go && is_file(aw_addr_reg) && w_strb_reg[0]) begin
            file_mem[aw_addr_reg[8:2]] <= w_data_reg[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel: one cycle from address to data
    assign arready = !rvalid_reg;
    assign rvalid  = rvalid_reg;
    assign rdata   = rdata_reg;
    assign rresp   = rresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else if (arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            if (is_file(araddr)) begin
                rdata_reg <= {24'h000000, file_mem[araddr[8:2]]};
            end else begin
                case (araddr)
                    ADDR_INSTR:  rdata_reg <= {18'h00000, instr_reg};
                    ADDR_WORK:   rdata_reg <= {24'h000000, work_reg};
                    ADDR_STATUS: rdata_reg <= {24'h000000, status_reg};
                    ADDR_CONFIG: rdata_reg <= {24'h000000, config_reg};
                    ADDR_LAST:   rdata_reg <= {29'h00000000, last_kind_reg};
                    default:     rdata_reg <= 32'h00000000;
                endcase
            end
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_exec(logic [5:0] op, logic d);
        exec_go && w_data_reg[13:8] == op && w_data_reg[DEST_BIT] == d;
    endsequence

    sequence s_answer;
        bvalid && bresp == RESP_OKAY;
    endsequence

    a_or_to_work: assert property (s_exec(OP_OR_FILE, 1'b0) |=>
        work_reg == ($past(work_reg) | $past(file_mem[exec_f])))
        else $error("OR result not placed in W");

    a_or_to_file: assert property (s_exec(OP_OR_FILE, 1'b1) |=>
        file_mem[$past(exec_f)] == ($past(work_reg) | $past(file_mem[exec_f]))
        && $stable(work_reg) && status_reg[7:1] == $past(status_reg[7:1]))
        else $error("OR result not written back to file");

    a_copy_to_work: assert property (s_exec(OP_COPY_FILE, 1'b0) |=>
        work_reg == $past(file_mem[exec_f]))
        else $error("Copy did not load W");

    a_copy_zero_test: assert property (s_exec(OP_COPY_FILE, 1'b1) |=>
        $stable(work_reg) && status_reg[ST_ZERO] == ($past(file_mem[exec_f]) == 8'h00))
        else $error("Copy to itself did not test zero");

    a_store_no_flag: assert property (exec_go && w_data_reg[13:7] == OP_STORE_WORK |=>
        file_mem[$past(exec_f)] == $past(work_reg) && $stable(status_reg))
        else $error("Store wrong or flags changed");

    a_config_load: assert property (exec_go && w_data_reg[13:0] == OP_CONFIG_LOAD |=>
        config_reg == $past(work_reg) && $stable(status_reg) && $stable(work_reg))
        else $error("Configuration load wrong");

    a_zero_flag: assert property (exec_go && zero_we |=>
        status_reg[ST_ZERO] == ($past(result) == 8'h00))
        else $error("Zero flag mismatch");

    a_one_cycle: assert property (exec_go |=> s_answer ##0 !aw_held_reg)
        else $error("Instruction did not complete in one cycle");

endmodule : mvo_core

// File: tb/mvo_prog_mem.sv
`timescale 1ns/10ps
module mvo_prog_mem (
    // Fetch
    input  wire logic [3:0]  pc,
    output logic      [13:0] word
);
    // Words outside the table read as an unsupported opcode rather than a stale word
    always_comb begin
        case (pc)
            4'h0:    word = 14'h0405;
            4'h1:    word = 14'h04FF;
            4'h2:    word = 14'h0800;
            4'h3:    word = 14'h08C0;
            4'h4:    word = 14'h0089;
            4'h5:    word = 14'h00FF;
            4'h6:    word = 14'h0062;
            4'h7:    word = 14'h3A00;
            4'h8:    word = 14'h0483;
            4'h9:    word = 14'h0803;
            default: word = 14'h3FFF;
        endcase
    end
endmodule : mvo_prog_mem

// File: tb/mvo_core_tb.sv
`timescale 1ns/10ps
module mvo_core_tb;
    import mvo_pkg::*;
    typedef struct packed {
        logic [6:0] fa;
        logic [7:0] w0, f0, s0, w1, f1, s1, c1;
        logic [2:0] lst;
    } mvo_row_t;
    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr  = '0;
    logic [11:0] araddr  = '0;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic [31:0] wdata   = '0;
    logic [3:0]  wstrb   = '0;
    logic [3:0]  pc      = '0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [13:0] word;
    int          bad_count = 0;
    int          n_tests   = 0;
    mvo_row_t    rows [8];

    always #12.5 aclk = ~aclk;

    mvo_core #(.FILE_DEPTH(128)) dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );
    mvo_prog_mem mem_u (.pc(pc), .word(word));

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask : chk

    function automatic logic [11:0] fad(input logic [6:0] f);
        return {FILE_PAGE, f, 2'b00};
    endfunction : fad

    // Address and data are offered together and each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                      output logic [1:0] rs);
        int   n;
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        rs = 2'h3;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= v;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (pa && awready) begin
                awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (pw && wready) begin
                wvalid <= 1'b0;
                pw = 1'b0;
            end
            if (bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 40) begin
            bad_count++;
            wrap_up();
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        int   n;
        logic pa;
        pa = 1'b1;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (pa && arready) begin
                arvalid <= 1'b0;
                pa = 1'b0;
            end
            if (rvalid) begin
                v = rdata;
                rs = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 40) begin
            bad_count++;
            wrap_up();
        end
    endtask : rd

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0]  rs;
        rd(a, v, rs);
        chk(nm, e, v);
        chk("rresp", {30'h0, RESP_OKAY}, {30'h0, rs});
    endtask : rd_chk

    // Fetch a word from program memory and hand it to the instruction register
    task automatic exec(input logic [3:0] p, input logic [3:0] s, output logic [1:0] rs);
        @(posedge aclk);
        pc <= p;
        @(negedge aclk);
        wr(ADDR_INSTR, {18'h0, word}, s, rs);
    endtask : exec

    ////////////////////////////////////////////////////////////////////////////////////
    initial begin
        rows[0] = '{7'h05, 8'h91, 8'h13, 8'h01, 8'h93, 8'h13, 8'h00, 8'h3C, 3'h1};
        rows[1] = '{7'h7F, 8'h00, 8'h00, 8'hFE, 8'h00, 8'h00, 8'hFF, 8'h3C, 3'h1};
        rows[2] = '{7'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h3C, 3'h3};
        rows[3] = '{7'h40, 8'h12, 8'h80, 8'hFF, 8'h12, 8'h80, 8'hFE, 8'h3C, 3'h3};
        rows[4] = '{7'h09, 8'h4F, 8'hFF, 8'h01, 8'h4F, 8'h4F, 8'h01, 8'h3C, 3'h2};
        rows[5] = '{7'h7F, 8'h00, 8'hA5, 8'hFE, 8'h00, 8'h00, 8'hFE, 8'h3C, 3'h2};
        rows[6] = '{7'h01, 8'hA5, 8'h66, 8'h01, 8'hA5, 8'h66, 8'h01, 8'hA5, 3'h6};
        rows[7] = '{7'h02, 8'h77, 8'h11, 8'h80, 8'h77, 8'h11, 8'h80, 8'h3C, 3'h0};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk("rst_work", ADDR_WORK, {24'h0, RST_WORK});
        rd_chk("rst_status", ADDR_STATUS, {24'h0, RST_STATUS});
        rd_chk("rst_config", ADDR_CONFIG, {24'h0, RST_CONFIG});
        rd_chk("rst_last", ADDR_LAST, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_WORK, {24'h0, rows[i].w0}, 4'h1, r);
            wr(fad(rows[i].fa), {24'h0, rows[i].f0}, 4'h1, r);
            wr(ADDR_STATUS, {24'h0, rows[i].s0}, 4'h1, r);
            wr(ADDR_CONFIG, 32'h3C, 4'h1, r);
            exec(4'(i), 4'h3, r);
            chk("exec_resp", {30'h0, RESP_OKAY}, {30'h0, r});
            rd_chk("work", ADDR_WORK, {24'h0, rows[i].w1});
            rd_chk("file", fad(rows[i].fa), {24'h0, rows[i].f1});
            rd_chk("status", ADDR_STATUS, {24'h0, rows[i].s1});
            rd_chk("config", ADDR_CONFIG, {24'h0, rows[i].c1});
            rd_chk("last", ADDR_LAST, {29'h0, rows[i].lst});
        end
        rd_chk("instr", ADDR_INSTR, 32'h3A00);
        // Back-to-back: the copy must see the value the OR just wrote back
        wr(ADDR_WORK, 32'h01, 4'h1, r);
        wr(fad(7'h03), 32'h02, 4'h1, r);
        exec(4'h8, 4'h3, r);
        exec(4'h9, 4'h3, r);
        rd_chk("b2b_work", ADDR_WORK, 32'h03);
        rd_chk("b2b_file", fad(7'h03), 32'h03);
        // Half-written instruction word is not executed
        exec(4'h2, 4'h1, r);
        chk("part_resp", {30'h0, RESP_OKAY}, {30'h0, r});
        rd_chk("part_work", ADDR_WORK, 32'h03);
        rd_chk("part_instr", ADDR_INSTR, 32'h0803);
        // A register write without byte lane 0 leaves the register alone
        wr(ADDR_WORK, 32'hEE, 4'h2, r);
        rd_chk("nostrb_work", ADDR_WORK, 32'h03);
        // Unmapped address
        wr(12'h014, 32'h5A, 4'hF, r);
        chk("bad_wr_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        rd(12'h014, d, r);
        chk("bad_rd_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("bad_rd_data", 32'h0, d);
        // Second reset in mid-run
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk("rst2_hs", 32'h1C, {27'h0, awready, wready, arready, bvalid, rvalid});
        rd_chk("rst2_work", ADDR_WORK, {24'h0, RST_WORK});
        rd_chk("rst2_status", ADDR_STATUS, {24'h0, RST_STATUS});
        rd_chk("rst2_instr", ADDR_INSTR, 32'h0);
        rd_chk("rst2_config", ADDR_CONFIG, {24'h0, RST_CONFIG});
        wrap_up();
    end
endmodule : mvo_core_tb
